// ===== common/pllc_pkg.sv
// Shared constants and types of the PLL output control block
package pllc_pkg;
	// Output counters: internal (global/regional) then external
	localparam int NUM_INT = 4;
	localparam int NUM_EXT = 4;
	localparam int NUM_CNT = NUM_INT + NUM_EXT;
	localparam int TAPS    = 8;
	localparam int TAP_W   = 3;
	localparam int CNT_W   = 8;
	localparam int DLY_W   = 4;
	localparam int DATA_W  = 32;
	localparam int ADDR_W  = 8;
	// Fine delay: 250 ps steps over -3.0 ns to +3.0 ns
	localparam int FINE_STEP_PS  = 250;
	localparam int FINE_RANGE_PS = 3000;
	localparam int FINE_LIMIT_PS = 3000;
	localparam int FINE_STEPS    = FINE_RANGE_PS / FINE_STEP_PS;
	localparam int FINE_LIMIT    = FINE_LIMIT_PS / FINE_STEP_PS;
	localparam int FINE_W        = 5;
	localparam int FINE_FLD_W    = 8;
	localparam int FINE_SR_D     = 2 * FINE_STEPS + 1;
	// Down spread 0.5 percent, triangular profile
	localparam int SPREAD_PERMIL = 5;
	localparam int SPREAD_DIV    = 1000 / SPREAD_PERMIL;
	localparam int TRI_W         = 8;
	localparam int TRI_MAX       = 255;
	localparam int ACC_W         = 17;
	localparam int SKIP_THRESH   = TRI_MAX * SPREAD_DIV;
	// Nominal VCO after a clear, reported only
	localparam int NOMINAL_MHZ   = 700;
	localparam int LOCK_REF_CYCLES = 16;
	localparam int LOCK_W        = 8;
	localparam int PHASE_LAG     = 1;
	// Register offsets
	localparam logic [ADDR_W-1:0] REG_MODE     = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_FINE     = 8'h08;
	localparam logic [ADDR_W-1:0] REG_MTAP     = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_CNT_BASE = 8'h20;
	localparam int CNT_SEL_LSB = 5;
	localparam int WORD_LSB    = 2;
	// Field positions of the mode register
	localparam int MODE_FB_LSB   = 0;
	localparam int MODE_INT_LSB  = 2;
	localparam int MODE_EXT_LSB  = 4;
	localparam int MODE_SPR_BIT  = 8;
	localparam int MODE_RATE_LSB = 16;
	// Field positions of the status register
	localparam int ST_LOCK = 0;
	localparam int ST_FREJ = 1;
	localparam int ST_CREJ = 2;
	localparam int ST_NOM  = 3;
	localparam int ST_RUN  = 4;
	localparam logic GATE_EN_RST = 1'b1;

	typedef enum logic [1:0] {
		PLLC_ZERO_DELAY,
		PLLC_EXT_FB,
		PLLC_NORMAL,
		PLLC_NO_COMP
	} pllc_fb_mode_type;

	// Post-scale counter setting, low bits of its register
	typedef struct packed {
		logic [TAP_W-1:0] tap;
		logic [CNT_W-1:0] init;
		logic [CNT_W-1:0] high;
		logic [CNT_W-1:0] low;
	} pllc_cnt_cfg_type;

	localparam pllc_cnt_cfg_type CNT_CFG_RST = 27'h0000101;
endpackage : pllc_pkg

// ===== rtl/pllc_clk_gate.sv
// Glitch-free output gate sampled on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module pllc_clk_gate (
	input  wire logic clk_in,      // System clock
	input  wire logic reset_in,    // Sync reset
	input  wire logic clk_raw_in,  // Counter output
	input  wire logic gate_in,     // High enables the output
	output logic      clk_out,     // Gated clock, registered
	output logic      enabled_out  // Gate state taken at last fall
);
	import pllc_pkg::*;

	logic raw_d_r;
	logic en_r;
	logic out_r;
	logic fall;

	// The gate only changes while the clock is low: no runt pulses
	assign fall        = raw_d_r & ~clk_raw_in;
	assign clk_out     = out_r;
	assign enabled_out = en_r;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			raw_d_r <= 1'b0;
			en_r    <= GATE_EN_RST;
			out_r   <= 1'b0;
		end else begin
			raw_d_r <= clk_raw_in;
			if (fall) begin
				en_r <= gate_in;
			end
			out_r <= clk_raw_in & en_r;
		end
	end
endmodule : pllc_clk_gate
`default_nettype wire

// ===== rtl/pllc_post_counter.sv
// Post-scale counter with tap start delay and high/low duty counts
`timescale 1ns/1ps
`default_nettype none
module pllc_post_counter (
	input  wire logic                       clk_in,   // System clock
	input  wire logic                       reset_in, // Sync reset
	input  wire logic                       run_in,   // Low holds cleared
	input  wire logic                       step_in,  // One VCO tap step
	input  wire logic [pllc_pkg::DLY_W-1:0] delay_in, // Start delay, taps
	input  wire pllc_pkg::pllc_cnt_cfg_type cfg_in,   // Counts and tap
	output logic                            clk_out   // Divided clock
);
	import pllc_pkg::*;

	logic [DLY_W-1:0] wait_r;
	logic [CNT_W:0]   pos_r;
	logic [CNT_W:0]   pos_inc;
	logic [CNT_W:0]   pos_nxt;
	logic [CNT_W:0]   total;
	logic             started_r;
	logic             clk_r;

	// Period is high plus low; position wraps at the end of it
	assign total   = {1'b0, cfg_in.high} + {1'b0, cfg_in.low};
	assign pos_inc = pos_r + 9'h001;
	assign pos_nxt = (pos_inc >= total) ? '0 : pos_inc;
	assign clk_out = clk_r;

	// Wait the tap delay, then start from the initial count
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wait_r    <= '0;
			pos_r     <= '0;
			started_r <= 1'b0;
			clk_r     <= 1'b0;
		end else if (!run_in) begin
			wait_r    <= delay_in;
			pos_r     <= '0;
			started_r <= 1'b0;
			clk_r     <= 1'b0;
		end else if (step_in && !started_r) begin
			if (wait_r == '0) begin
				started_r <= 1'b1;
				pos_r     <= {1'b0, cfg_in.init};
				clk_r     <= cfg_in.init < cfg_in.high;
			end else begin
				wait_r <= wait_r - 4'h1;
			end
		end else if (step_in) begin
			pos_r <= pos_nxt;
			clk_r <= pos_nxt < {1'b0, cfg_in.high};
		end
	end
endmodule : pllc_post_counter
`default_nettype wire

// ===== rtl/pllc_top.sv
// PLL output control: feedback modes, counters, lock, gating, spread
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module pllc_top #(
	parameter int LOCK_CYCLES = pllc_pkg::LOCK_REF_CYCLES
) (
	input  wire logic                         clk_in,          // 100 MHz
	input  wire logic                         reset_in,        // Sync reset
	input  wire logic [pllc_pkg::ADDR_W-1:0]  addr_in,         // Byte addr
	input  wire logic [pllc_pkg::DATA_W-1:0]  wdata_in,        // Write data
	input  wire logic                         wr_in,           // Write strb
	input  wire logic                         rd_in,           // Read strb
	output logic      [pllc_pkg::DATA_W-1:0]  rdata_out,       // Read data
	input  wire logic                         ref_clk_in,      // Reference
	input  wire logic                         feedback_input_pin_in, // Fb
	input  wire logic                         global_enable_in, // Enable
	input  wire logic                         counter_clear_in, // Clear
	input  wire logic                         detector_gate_in, // Detector
	input  wire logic [pllc_pkg::NUM_INT-1:0] clk_gate_in,     // Int gates
	input  wire logic [pllc_pkg::NUM_EXT-1:0] ext_gate_in,     // Ext gates
	output logic      [pllc_pkg::NUM_INT-1:0] clk_int_out,     // Int clocks
	output logic      [pllc_pkg::NUM_EXT-1:0] clk_ext_out,     // Ext clocks
	output logic                              fb_clk_out,      // To board
	output logic                              lock_out         // Lock
);
	import pllc_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Decoding helpers

	// Address falls in the counter setting window
	function automatic logic cnt_hit(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:CNT_SEL_LSB] == REG_CNT_BASE[ADDR_W-1:CNT_SEL_LSB];
	endfunction : cnt_hit

	// Fine delay set is legal: each in range and spread under limit
	function automatic logic fine_ok(
		input logic [NUM_INT*FINE_FLD_W-1:0] v
	);
		logic signed [FINE_W-1:0] f;
		logic signed [FINE_W-1:0] lo;
		logic signed [FINE_W-1:0] hi;
		logic signed [FINE_W:0]   d;
		logic                     ok;
		lo = 5'sh0c;
		hi = 5'sh14;
		ok = 1'b1;
		for (int i = 0; i < NUM_INT; i++) begin
			f = v[i*FINE_FLD_W +: FINE_W];
			if (f > FINE_STEPS || f < -FINE_STEPS) begin
				ok = 1'b0;
			end
			if (f < lo) begin
				lo = f;
			end
			if (f > hi) begin
				hi = f;
			end
		end
		d = hi - lo;
		return ok && (d < FINE_LIMIT);
	endfunction : fine_ok

	// Uncompensated path lag of counter c under the feedback mode
	function automatic logic lag_of(
		input pllc_fb_mode_type m,
		input int               c,
		input logic [1:0]       isel,
		input logic [1:0]       esel
	);
		logic ext;
		ext = c >= NUM_INT;
		unique case (m)
			PLLC_ZERO_DELAY,
			PLLC_EXT_FB: lag_of = !(ext && (c - NUM_INT) == int'(esel));
			PLLC_NORMAL: lag_of = ext || (c != int'(isel));
			PLLC_NO_COMP: lag_of = 1'b1;
		endcase
	endfunction : lag_of

	////////////////////////////////////////////////////////////////////
	// State

	pllc_fb_mode_type            mode_r;
	logic [1:0]                  int_sel_r;
	logic [1:0]                  ext_sel_r;
	logic                        spread_en_r;
	logic [TRI_W-1:0]            spread_rate_r;
	logic [TAP_W-1:0]            m_tap_r;
	logic [NUM_INT*FINE_FLD_W-1:0] fine_r;
	pllc_cnt_cfg_type            cnt_cfg_r [NUM_CNT];
	logic                        fine_rej_r;
	logic                        cfg_rej_r;
	logic                        run_r;
	logic                        nominal_r;
	logic                        ref_d_r;
	logic                        fb_d_r;
	logic                        fb_seen_r;
	logic                        fb_en_d_r;
	logic [LOCK_W-1:0]           lock_cnt_r;
	logic                        lock_r;
	logic                        step_r;
	logic [TRI_W-1:0]            tri_r;
	logic                        tri_up_r;
	logic [TRI_W-1:0]            rate_cnt_r;
	logic [ACC_W-1:0]            acc_r;
	logic [ACC_W-1:0]            acc_nxt;
	logic [DATA_W-1:0]           rdata_r;
	logic [NUM_INT-1:0]          int_out_r;
	logic [NUM_EXT-1:0]          ext_out_r;
	logic                        fb_out_r;
	logic [FINE_SR_D-1:0]        fine_sr_r [NUM_INT];

	logic [NUM_CNT-1:0] raw_clk;
	logic [NUM_CNT-1:0] gated_clk;
	logic [NUM_CNT-1:0] gate_state;
	logic [NUM_CNT-1:0] gate_all;

	////////////////////////////////////////////////////////////////////
	// Register port decode

	logic                      wr_mode;
	logic                      wr_fine;
	logic                      wr_mtap;
	logic                      wr_cnt;
	logic                      cfg_wr;
	logic [2:0]                cnt_idx;
	logic [DATA_W-1:0]         mode_word;
	logic [DATA_W-1:0]         status_word;
	logic [DATA_W-1:0]         rd_val;

	assign wr_mode = wr_in && (addr_in == REG_MODE);
	assign wr_fine = wr_in && (addr_in == REG_FINE);
	assign wr_mtap = wr_in && (addr_in == REG_MTAP);
	assign wr_cnt  = wr_in && cnt_hit(addr_in);
	assign cfg_wr  = wr_mode || wr_mtap || wr_cnt;
	assign cnt_idx = addr_in[CNT_SEL_LSB-1:WORD_LSB];

	// Read words; unmapped offsets read as zero
	assign mode_word = (DATA_W'(mode_r) << MODE_FB_LSB)
		| (DATA_W'(int_sel_r) << MODE_INT_LSB)
		| (DATA_W'(ext_sel_r) << MODE_EXT_LSB)
		| (DATA_W'(spread_en_r) << MODE_SPR_BIT)
		| (DATA_W'(spread_rate_r) << MODE_RATE_LSB);
	assign status_word = (DATA_W'(lock_r) << ST_LOCK)
		| (DATA_W'(fine_rej_r) << ST_FREJ)
		| (DATA_W'(cfg_rej_r) << ST_CREJ)
		| (DATA_W'(nominal_r) << ST_NOM)
		| (DATA_W'(run_r) << ST_RUN);
	assign rd_val = cnt_hit(addr_in) ? DATA_W'(cnt_cfg_r[cnt_idx])
		: (addr_in == REG_MODE)   ? mode_word
		: (addr_in == REG_STATUS) ? status_word
		: (addr_in == REG_FINE)   ? DATA_W'(fine_r)
		: (addr_in == REG_MTAP)   ? DATA_W'(m_tap_r)
		: '0;

	////////////////////////////////////////////////////////////////////
	// Loop control and lock

	logic ref_rise;
	logic fb_rise;
	logic hold_off;
	logic fb_relock;
	logic lock_drop;
	logic ext_fb;

	assign ref_rise = ref_clk_in & ~ref_d_r;
	assign fb_rise  = feedback_input_pin_in & ~fb_d_r;
	assign ext_fb   = mode_r == PLLC_EXT_FB;
	assign hold_off = !global_enable_in || counter_clear_in;
	assign fb_relock = ext_fb && gate_state[NUM_INT + int'(ext_sel_r)]
		&& !fb_en_d_r;
	assign lock_drop = hold_off || !detector_gate_in || fb_relock
		|| (ext_fb && ref_rise && !fb_seen_r);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			run_r     <= 1'b0;
			nominal_r <= 1'b1;
		end else begin
			if (hold_off) begin
				run_r <= 1'b0;
			end else if (ref_rise) begin
				run_r <= 1'b1;
			end
			if (counter_clear_in) begin
				nominal_r <= 1'b1;
			end else if (lock_r) begin
				nominal_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ref_d_r    <= 1'b0;
			fb_d_r     <= 1'b0;
			fb_seen_r  <= 1'b0;
			fb_en_d_r  <= GATE_EN_RST;
			lock_cnt_r <= '0;
			lock_r     <= 1'b0;
		end else begin
			ref_d_r   <= ref_clk_in;
			fb_d_r    <= feedback_input_pin_in;
			fb_en_d_r <= gate_state[NUM_INT + int'(ext_sel_r)];
			fb_seen_r <= fb_rise || (fb_seen_r && !ref_rise);
			if (lock_drop) begin
				lock_cnt_r <= '0;
			end else if (ref_rise && lock_cnt_r != LOCK_W'(LOCK_CYCLES)) begin
				lock_cnt_r <= lock_cnt_r + 8'h01;
			end
			lock_r <= !lock_drop && lock_cnt_r == LOCK_W'(LOCK_CYCLES);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Settings registers

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mode_r        <= PLLC_NORMAL;
			int_sel_r     <= '0;
			ext_sel_r     <= '0;
			spread_en_r   <= 1'b0;
			spread_rate_r <= '0;
			m_tap_r       <= '0;
			cfg_rej_r     <= 1'b0;
		end else if (cfg_wr && run_r) begin
			cfg_rej_r <= 1'b1;
		end else if (cfg_wr) begin
			cfg_rej_r <= 1'b0;
			if (wr_mode) begin
				mode_r <= pllc_fb_mode_type'(wdata_in[MODE_FB_LSB +: 2]);
				int_sel_r     <= wdata_in[MODE_INT_LSB +: 2];
				ext_sel_r     <= wdata_in[MODE_EXT_LSB +: 2];
				spread_en_r   <= wdata_in[MODE_SPR_BIT];
				spread_rate_r <= wdata_in[MODE_RATE_LSB +: TRI_W];
			end
			if (wr_mtap) begin
				m_tap_r <= wdata_in[TAP_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int c = 0; c < NUM_CNT; c++) begin
				cnt_cfg_r[c] <= CNT_CFG_RST;
			end
		end else if (wr_cnt && !run_r) begin
			cnt_cfg_r[cnt_idx] <= pllc_cnt_cfg_type'(wdata_in[26:0]);
		end
	end

	// fine delay always writable, bad sets refused
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fine_r     <= '0;
			fine_rej_r <= 1'b0;
			rdata_r    <= '0;
		end else begin
			if (wr_fine) begin
				fine_rej_r <= !fine_ok(wdata_in);
			end
			if (wr_fine && fine_ok(wdata_in)) begin
				fine_r <= wdata_in;
			end
			rdata_r <= rd_in ? rd_val : '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// VCO step with triangular down spread

	// Skipping a step every so often lowers the mean frequency only
	assign acc_nxt = acc_r + ACC_W'(tri_r);

	always_ff @(posedge clk_in) begin
		if (reset_in || !spread_en_r) begin
			tri_r      <= '0;
			tri_up_r   <= 1'b1;
			rate_cnt_r <= '0;
			acc_r      <= '0;
			step_r     <= 1'b1;
		end else begin
			if (rate_cnt_r >= spread_rate_r) begin
				rate_cnt_r <= '0;
				tri_r      <= tri_up_r ? tri_r + 8'h01 : tri_r - 8'h01;
				if (tri_up_r && tri_r == TRI_W'(TRI_MAX - 1)) begin
					tri_up_r <= 1'b0;
				end else if (!tri_up_r && tri_r == 8'h01) begin
					tri_up_r <= 1'b1;
				end
			end else begin
				rate_cnt_r <= rate_cnt_r + 8'h01;
			end
			step_r <= acc_nxt < ACC_W'(SKIP_THRESH);
			acc_r  <= (acc_nxt < ACC_W'(SKIP_THRESH)) ? acc_nxt
				: acc_nxt - ACC_W'(SKIP_THRESH);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output counters and gates

	assign gate_all = {ext_gate_in, clk_gate_in};

	for (genvar c = 0; c < NUM_CNT; c++) begin : g_cnt
		logic [DLY_W-1:0] dly;
		assign dly = DLY_W'(cnt_cfg_r[c].tap) + DLY_W'(m_tap_r)
			+ DLY_W'(lag_of(mode_r, c, int_sel_r, ext_sel_r));

		pllc_post_counter u_cnt (
			.clk_in   (clk_in),
			.reset_in (reset_in),
			.run_in   (run_r),
			.step_in  (step_r),
			.delay_in (dly),
			.cfg_in   (cnt_cfg_r[c]),
			.clk_out  (raw_clk[c])
		);

		pllc_clk_gate u_gate (
			.clk_in      (clk_in),
			.reset_in    (reset_in),
			.clk_raw_in  (raw_clk[c]),
			.gate_in     (gate_all[c]),
			.clk_out     (gated_clk[c]),
			.enabled_out (gate_state[c])
		);
	end

	////////////////////////////////////////////////////////////////////
	// Fine delay lines and output registers

	// Centre tap is zero delay; the line costs FINE_STEPS + 1 cycles
	for (genvar i = 0; i < NUM_INT; i++) begin : g_fine
		logic [FINE_W-1:0] sel;
		assign sel = fine_r[i*FINE_FLD_W +: FINE_W] + FINE_W'(FINE_STEPS);

		always_ff @(posedge clk_in) begin
			if (reset_in || hold_off) begin
				fine_sr_r[i] <= '0;
				int_out_r[i] <= 1'b0;
			end else begin
				fine_sr_r[i] <= {fine_sr_r[i][FINE_SR_D-2:0], gated_clk[i]};
				int_out_r[i] <= fine_sr_r[i][sel];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in || hold_off) begin
			ext_out_r <= '0;
			fb_out_r  <= 1'b0;
		end else begin
			ext_out_r <= gated_clk[NUM_CNT-1:NUM_INT];
			fb_out_r  <= ext_fb && gated_clk[NUM_INT + int'(ext_sel_r)];
		end
	end

	assign rdata_out   = rdata_r;
	assign clk_int_out = int_out_r;
	assign clk_ext_out = ext_out_r;
	assign fb_clk_out  = fb_out_r;
	assign lock_out    = lock_r;
endmodule : pllc_top
`default_nettype wire

// ===== testbench/pllc_sys_model.sv
// System side: reference clock, board feedback trace, lock filter
`timescale 1ns/1ps
`default_nettype none
module pllc_sys_model #(
	parameter int HALF = 4,
	parameter int QUAL = 4
) (
	input  wire logic clk_in,      // Clock
	input  wire logic reset_in,    // Reset
	input  wire logic run_in,      // Low halts reference
	input  wire logic loop_in,     // Joins feedback trace
	input  wire logic fb_clk_in,   // Clock to board
	input  wire logic lock_in,     // Raw lock
	output logic      ref_clk_out, // Reference
	output logic      fb_pin_out,  // Feedback pin
	output logic      lock_ok_out  // Qualified lock
);
	logic [7:0] div_r;
	logic [7:0] qual_r;
	logic       ref_d_r;
	// A halted source stays at its level, as a lost input would
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			div_r <= '0;
			ref_clk_out <= 1'b0;
		end else if (run_in) begin
			div_r <= (div_r == 8'(HALF - 1)) ? '0 : div_r + 8'h01;
			ref_clk_out <= ref_clk_out ^ (div_r == 8'(HALF - 1));
		end
	end
	// external output looped on the board
	// Open trace has a pull-down, so it reads low unless joined
	assign fb_pin_out = loop_in & fb_clk_in;
	// raw lock trusted after QUAL reference edges
	always_ff @(posedge clk_in) begin
		ref_d_r <= ref_clk_out;
		if (reset_in || !lock_in) begin
			qual_r <= '0;
		end else if (ref_clk_out && !ref_d_r && qual_r != 8'hff) begin
			qual_r <= qual_r + 8'h01;
		end
	end
	assign lock_ok_out = (qual_r >= 8'(QUAL));
endmodule : pllc_sys_model
`default_nettype wire

// ===== testbench/pllc_top_checker.sv
// Port assertions for the PLL output control block
`timescale 1ns/1ps
`default_nettype none
module pllc_top_checker #(
	parameter int LOCK_CYCLES = 16
) (
	input wire logic                         clk_in,           // Clock
	input wire logic                         reset_in,         // Reset
	input wire logic                         global_enable_in, // Enable
	input wire logic                         counter_clear_in, // Clear
	input wire logic                         detector_gate_in, // Detector
	input wire logic [pllc_pkg::NUM_INT-1:0] clk_gate_in,      // Gates
	input wire logic [pllc_pkg::NUM_INT-1:0] clk_int_out,      // Int clk
	input wire logic [pllc_pkg::NUM_EXT-1:0] clk_ext_out,      // Ext clk
	input wire logic                         lock_out          // Lock
);
	import pllc_pkg::*;
	logic [9:0] off_r;
	logic [9:0] clr_r;
	logic [9:0] gof_r;
	logic [9:0] quiet_r;
	logic       cause;
	assign cause = !global_enable_in || counter_clear_in || !detector_gate_in;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	////////////////////////////////////////////////////////////////////////
	// Saturating run lengths; long holds cover the fine delay latency
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			off_r <= '0;
			clr_r <= '0;
			gof_r <= '0;
			quiet_r <= '0;
		end else begin
			off_r <= global_enable_in ? '0 : off_r + 10'(off_r != '1);
			clr_r <= !counter_clear_in ? '0 : clr_r + 10'(clr_r != '1);
			gof_r <= (clk_gate_in != '0) ? '0 : gof_r + 10'(gof_r != '1);
			quiet_r <= cause ? '0 : quiet_r + 10'(quiet_r != '1);
		end
	end
	////////////////////////////////////////////////////////////////////////
	property p_en_lock;
		!global_enable_in [*2] |-> !lock_out;
	endproperty
	a_en_lock: assert property (p_en_lock)
		else $error("lock with enable low");
	property p_en_gnd;
		off_r >= 10'd48 |-> clk_int_out == '0 && clk_ext_out == '0;
	endproperty
	a_en_gnd: assert property (p_en_gnd)
		else $error("clock with enable low");
	property p_clr_lock;
		counter_clear_in [*2] |-> !lock_out;
	endproperty
	a_clr_lock: assert property (p_clr_lock)
		else $error("lock during clear");
	property p_clr_gnd;
		clr_r >= 10'd48 |-> clk_int_out == '0 && clk_ext_out == '0;
	endproperty
	a_clr_gnd: assert property (p_clr_gnd)
		else $error("clock during clear");
	property p_det_lock;
		!detector_gate_in [*2] |-> !lock_out;
	endproperty
	a_det_lock: assert property (p_det_lock)
		else $error("lock with detector off");
	property p_lock_qual;
		$rose(lock_out) |-> quiet_r >= 10'(2 * LOCK_CYCLES);
	endproperty
	a_lock_qual: assert property (p_lock_qual)
		else $error("lock too early");
	property p_gate_keep;
		lock_out && !cause && $changed(clk_gate_in) |=> lock_out;
	endproperty
	a_gate_keep: assert property (p_gate_keep)
		else $error("gating dropped lock");
	property p_gate_off;
		gof_r >= 10'd600 |-> clk_int_out == '0;
	endproperty
	a_gate_off: assert property (p_gate_off)
		else $error("gated clock runs");
endmodule : pllc_top_checker
bind pllc_top pllc_top_checker #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
	.clk_in(clk_in), .reset_in(reset_in),
	.global_enable_in(global_enable_in), .counter_clear_in(counter_clear_in),
	.detector_gate_in(detector_gate_in), .clk_gate_in(clk_gate_in),
	.clk_int_out(clk_int_out), .clk_ext_out(clk_ext_out), .lock_out(lock_out)
);
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the PLL output control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pllc_pkg::*;
	logic               clk_in = 1'b0;
	logic               reset_in = 1'b1;
	logic [ADDR_W-1:0]  addr = '0;
	logic [DATA_W-1:0]  wdata = '0;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	logic               en = 1'b1;
	logic               clr = 1'b1;
	logic               det = 1'b1;
	logic [NUM_INT-1:0] gate = '1;
	logic [NUM_EXT-1:0] egate = '1;
	logic               run = 1'b1;
	logic               loop = 1'b0;
	logic [DATA_W-1:0]  rdata;
	logic [DATA_W-1:0]  d;
	logic [NUM_INT-1:0] ci;
	logic [NUM_EXT-1:0] ce;
	logic               rclk, fbp, fbc, lock, lok, pv;
	int                 fails = 0;
	int                 cmp_count = 0;
	int                 hi, rs, ia, n;
	always #5 clk_in = ~clk_in;
	pllc_top #(.LOCK_CYCLES(4)) dut (.clk_in(clk_in), .reset_in(reset_in),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .ref_clk_in(rclk), .feedback_input_pin_in(fbp),
		.global_enable_in(en), .counter_clear_in(clr),
		.detector_gate_in(det), .clk_gate_in(gate), .ext_gate_in(egate),
		.clk_int_out(ci), .clk_ext_out(ce), .fb_clk_out(fbc),
		.lock_out(lock));
	pllc_sys_model #(.HALF(4), .QUAL(4)) sys (.clk_in(clk_in),
		.reset_in(reset_in), .run_in(run), .loop_in(loop), .fb_clk_in(fbc),
		.lock_in(lock), .ref_clk_out(rclk), .fb_pin_out(fbp),
		.lock_ok_out(lok));
	////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic chk1(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask : chk1
	task automatic wr32(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : wr32
	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
		input logic [DATA_W-1:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 d = rdata;
		chk(d & m, e);
	endtask : rc
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_in);
		#1;
	endtask : cyc
	task automatic watch(input int c);
		#1 pv = ce[0];
		hi = 0;
		rs = 0;
		ia = 0;
		repeat (c) begin
			cyc(1);
			rs += int'(ce[0] && !pv);
			hi += int'(ce[0]);
			ia += int'(ci != '0);
			pv = ce[0];
		end
	endtask : watch
	// Bounded wait; a missing lock ends the run
	task automatic wait_lock;
		n = 0;
		while (lock !== 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk1(n < 3000, 1'b1);
		if (n >= 3000) results();
	endtask : wait_lock
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_in);
		reset_in <= 1'b0;
		rc(REG_MODE, '1, 32'h2);
		rc(REG_CNT_BASE, '1, 32'h101);
		rc(8'h10, '1, 32'h0);
		rc(REG_STATUS, 32'h1f, 32'h8);
		for (int m = 0; m < 4; m++) begin
			wr32(REG_MODE, m);
			rc(REG_MODE, '1, m);
		end
		wr32(REG_MODE, 32'h2);
		wr32(8'h30, 32'h203);
		rc(8'h30, '1, 32'h203);
		wr32(REG_FINE, 32'hd);
		rc(REG_STATUS, 32'h2, 32'h2);
		wr32(REG_FINE, 32'h1a06);
		rc(REG_STATUS, 32'h2, 32'h2);
		wr32(REG_FINE, 32'h1b06);
		rc(REG_STATUS, 32'h2, 32'h0);
		rc(REG_FINE, '1, 32'h1b06);
		clr <= 1'b0;
		cyc(40);
		watch(50);
		chk(hi, 20);
		chk(rs, 10);
		wr32(8'h30, 32'h303);
		rc(REG_STATUS, 32'h14, 32'h14);
		rc(8'h30, '1, 32'h203);
		wr32(REG_FINE, 32'h0);
		rc(REG_STATUS, 32'h2, 32'h0);
		wait_lock();
		rc(REG_STATUS, 32'h9, 32'h1);
		cyc(100);
		chk1(lok, 1'b1);
		gate <= '0;
		cyc(650);
		chk({28'h0, ci}, 32'h0);
		chk1(lock, 1'b1);
		gate <= '1;
		cyc(60);
		watch(40);
		chk1(ia > 0, 1'b1);
		chk1(lock, 1'b1);
		det <= 1'b0;
		run <= 1'b0;
		cyc(10);
		chk1(lock, 1'b0);
		watch(50);
		chk1(rs > 0, 1'b1);
		det <= 1'b1;
		run <= 1'b1;
		en <= 1'b0;
		cyc(60);
		chk({24'h0, ci, ce}, 32'h0);
		en <= 1'b1;
		wait_lock();
		clr <= 1'b1;
		cyc(60);
		chk({24'h0, ci, ce}, 32'h0);
		rc(REG_STATUS, 32'h19, 32'h8);
		wr32(REG_MODE, 32'h1);
		clr <= 1'b0;
		loop <= 1'b1;
		wait_lock();
		egate <= 4'he;
		cyc(40);
		egate <= 4'hf;
		cyc(12);
		chk1(lock, 1'b0);
		// Lock is gone: clear before retuning keeps the phases in order
		clr <= 1'b1;
		wr32(REG_MTAP, 32'h5);
		rc(REG_MTAP, '1, 32'h5);
		wr32(REG_MODE, 32'h102);
		clr <= 1'b0;
		cyc(60);
		// Down spread only: a few steps skipped, never an extra edge
		watch(4000);
		chk1(rs > 790 && rs < 800, 1'b1);
		results();
	end
endmodule : tb_top
`default_nettype wire
